// File: test/can_filter_control_bench.sv
// Purpose: Self-checking bench for the filter control register block.
// Assumes: Single word transfers; the slave answers with zero wait states.
// Notes:   Each scenario writes, reads back and inspects the filter outputs.
`timescale 1ns/10ps
module can_filter_control_bench import cfc_pkg::*;;
   logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [7:0]    haddr;
   logic [1:0]    htrans;
   logic [2:0]    hsize;
   logic [31:0]   hwdata, hrdata, q;
   logic [5:0]    filter_active_bit;
   logic [11:0]   filter_mask_choice;
   logic [29:0]   filter_fifo_target;
   logic [23:0]   filter_mask_onehot;
   logic [191:0]  filter_fifo_onehot;
   int            err_total = 0, n_compared = 0, cyc = 0;
   assign hready = hreadyout;
   cfc_filter_ctrl cfc_filter_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready, .hwdata, .hrdata, .hreadyout, .hresp, .filter_active_bit, .filter_mask_choice,
      .filter_fifo_target, .filter_mask_onehot, .filter_fifo_onehot);
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      hsize <= CFC_HSIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= CFC_HTRANS_IDLE;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer
   task automatic fields_b;
      xfer(1'b1, CFC_OFF_CTRL_B, 32'h9FA0_C1FE);
      xfer(1'b0, CFC_OFF_CTRL_B, 32'h0000_0000);
      chk("ctrl_b", q, 32'h9FA0_C1FE);
      chk("active", filter_active_bit, 32'h0000_003C);
      chk("mask_onehot", filter_mask_onehot[23:8], 32'h0000_1248);
      chk("fifo23", filter_fifo_onehot[191:160], 32'h8000_0000);
      chk("fifo21", filter_fifo_onehot[127:96], 32'h0000_0002);
   endtask : fields_b
   task automatic lock_b;
      xfer(1'b1, CFC_OFF_CTRL_B, 32'h0000_0000);
      chk("hresp locked", 32'(hresp), 32'h0000_0000);
      xfer(1'b0, CFC_OFF_CTRL_B, 32'h0000_0000);
      chk("ctrl_b locked", q, 32'h1F20_417E);
      chk("mask off", filter_mask_onehot, 32'h0000_0000);
      chk("fifo off", 32'(|filter_fifo_onehot), 32'h0000_0000);
   endtask : lock_b
   task automatic fields_a;
      xfer(1'b1, CFC_OFF_CTRL_A, 32'hFFFF_FFFF);
      xfer(1'b0, CFC_OFF_CTRL_A, 32'h0000_0000);
      chk("ctrl_a", q, 32'hFFFF_0000);
      chk("mask18", filter_mask_choice[1:0], 32'h0000_0003);
      xfer(1'b1, CFC_OFF_CTRL_A, 32'h0000_FFFF);
      xfer(1'b0, CFC_OFF_CTRL_A, 32'h0000_0000);
      chk("ctrl_a locked", q, 32'h7F7F_0000);
      chk("fifo18", filter_fifo_target[4:0], 32'h0000_001F);
      xfer(1'b1, 8'h08, 32'hFFFF_FFFF);
      xfer(1'b0, 8'h08, 32'h0000_0000);
      chk("unmapped", q, 32'h0000_0000);
   endtask : fields_a
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // A hung handshake is cut short here and counted as a mismatch.
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      {hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, CFC_OFF_CTRL_B, 32'h0000_0000);
      chk("reset_b", q, CFC_RESET_CTRL);
      fields_b();
      lock_b();
      fields_a();
      summarize();
   end
endmodule : can_filter_control_bench

// File: test/cfc_filter_checker.sv
// Purpose: Assertions on the filter control register block.
// Assumes: Zero-wait slave; filter outputs follow the stored byte by one edge.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/10ps
module cfc_filter_checker
   import cfc_pkg::*;
(
   // Clock and reset.
   input wire logic                     hclk,
   input wire logic                     hresetn,
   // Bus side.
   input wire logic                     hsel,
   input wire logic [CFC_ADDR_W-1:0]    haddr,
   input wire logic [1:0]               htrans,
   input wire logic                     hwrite,
   input wire logic [2:0]               hsize,
   input wire logic                     hready,
   input wire logic [31:0]              hwdata,
   input wire logic [31:0]              hrdata,
   // Filter side.
   input wire logic [CFC_NFILT-1:0]     filter_active_bit,
   input wire logic [CFC_NFILT*2-1:0]   filter_mask_choice,
   input wire logic [CFC_NFILT*5-1:0]   filter_fifo_target,
   input wire logic [CFC_NFILT*4-1:0]   filter_mask_onehot,
   input wire logic [CFC_NFILT*32-1:0]  filter_fifo_onehot
);
   logic take;
   assign take = hsel && hready && htrans[1] && hsize == CFC_HSIZE_WORD;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   enable_write_a: assert property (take && hwrite && haddr == CFC_OFF_CTRL_B
      |-> ##3 filter_active_bit[5] == $past(hwdata[31], 2)) else $error("f23 enable");
   low_byte_a: assert property (take && hwrite && haddr == CFC_OFF_CTRL_B
      |-> ##3 filter_active_bit[2] == $past(hwdata[7], 2)) else $error("f20 enable");
   f18_enable_a: assert property (take && hwrite && haddr == CFC_OFF_CTRL_A
      |-> ##3 filter_active_bit[0] == $past(hwdata[23], 2)) else $error("f18 enable");
   low_half_a: assert property (take && !hwrite && haddr == CFC_OFF_CTRL_A
      |-> ##1 hrdata[15:0] == 16'h0000) else $error("ctrl_a low half");
   for (genvar i = 0; i < CFC_NFILT; i++) begin : g_filt
      mask_decode_a: assert property (filter_active_bit[i] |->
         filter_mask_onehot[i*4+:4] == 4'h1 << filter_mask_choice[i*2+:2]) else $error("mask");
      fifo_decode_a: assert property (filter_active_bit[i] |->
         filter_fifo_onehot[i*32+:32] == 32'h0000_0001 << filter_fifo_target[i*5+:5])
         else $error("fifo");
      idle_silent_a: assert property (!filter_active_bit[i] |->
         filter_mask_onehot[i*4+:4] == 4'h0 && filter_fifo_onehot[i*32+:32] == 32'h0000_0000)
         else $error("idle");
      field_lock_a: assert property (filter_active_bit[i]
         && $past(filter_active_bit[i]) |->
         $stable(filter_mask_choice[i*2+:2]) && $stable(filter_fifo_target[i*5+:5]))
         else $error("lock");
   end
endmodule : cfc_filter_checker
bind cfc_filter_ctrl cfc_filter_checker cfc_filter_checker_i (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata, .filter_active_bit, .filter_mask_choice,
   .filter_fifo_target, .filter_mask_onehot, .filter_fifo_onehot);

// File: verilog/cfc_filter_ctrl.sv
// Purpose: AHB-Lite register block for the controls of filters 18 to 23.
// Assumes: Single-word transfers; one-cycle data phase, always OKAY.
// Notes:   Outputs give per-filter enables, selectors and one-hot routing.
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps

// Functional notes
// RULE1 - Each filter has one enable bit
// RULE2 - Two-bit selector picks one of four masks
// RULE3 - Five-bit selector picks FIFO buffer 0 to 31
// RULE4 - Selector fields locked while filter enabled
// RULE5 - Second register holds filters 23 down to 20
// RULE6 - First register holds filters 19 and 18
// RULE7 - Disabled filter never accepts or routes messages
module cfc_filter_ctrl
   import cfc_pkg::*;
(
   // Clock and reset.
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   // AHB-Lite slave.
   input  wire logic                          hsel,
   input  wire logic [CFC_ADDR_W-1:0]         haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic                          hready,
   input  wire logic [31:0]                   hwdata,
   output logic      [31:0]                   hrdata,
   output logic                               hreadyout,
   output logic                               hresp,
   // Filter controls toward matching logic and FIFO storage.
   output logic      [CFC_NFILT-1:0]          filter_active_bit,
   output logic      [CFC_NFILT*2-1:0]        filter_mask_choice,
   output logic      [CFC_NFILT*5-1:0]        filter_fifo_target,
   output logic      [CFC_NFILT*4-1:0]        filter_mask_onehot,
   output logic      [CFC_NFILT*32-1:0]       filter_fifo_onehot
);

   cfc_phase_type         phase;
   cfc_phase_type         next_phase;
   logic [CFC_ADDR_W-1:0] dp_addr;
   logic [CFC_ADDR_W-1:0] next_dp_addr;
   logic [31:0]           next_hrdata;
   logic [7:0]            slot_byte [CFC_NFILT];
   logic [CFC_NFILT-1:0]  slot_wr;
   logic [31:0]           ctrl_a;
   logic [31:0]           ctrl_b;
   logic [31:0]           view_a;
   logic [31:0]           view_b;
   logic [CFC_NFILT-1:0]  dec_active;
   logic [CFC_NFILT*4-1:0]  dec_mask;
   logic [CFC_NFILT*32-1:0] dec_fifo;

   // Register image: filter 18 in byte 2 of the first word, 19 in byte 3,
   // then 20 to 23 in bytes 0 to 3 of the second word.
   always_comb begin
      ctrl_a = {slot_byte[1], slot_byte[0], CFC_RESET_HALF}; // [RULE6]
      ctrl_b = {slot_byte[5], slot_byte[4], slot_byte[3], slot_byte[2]}; // [RULE5]
   end

   function automatic logic is_valid_xfer(input logic [1:0] trans, input logic [2:0] size);
      is_valid_xfer = trans[1] && (size == CFC_HSIZE_WORD);
   endfunction : is_valid_xfer

   // Stored byte as it stands after a write: the enable bit always follows the
   // new data, the selectors only while the stored enable is clear.
   function automatic logic [7:0] merge_byte(input logic [7:0] old_byte,
                                             input logic [7:0] new_byte);
      merge_byte = old_byte;
      merge_byte[CFC_ACTIVE_POS] = new_byte[CFC_ACTIVE_POS];
      if (!old_byte[CFC_ACTIVE_POS]) begin
         merge_byte[CFC_MASK_HI:CFC_FIFO_LO] = new_byte[CFC_MASK_HI:CFC_FIFO_LO];
      end
   endfunction : merge_byte

   // Address phase capture.
   always_comb begin
      next_phase   = CFC_DP_IDLE;
      next_dp_addr = dp_addr;
      if (hsel && hready && is_valid_xfer(htrans, hsize)) begin
         next_phase   = hwrite ? CFC_DP_WRITE : CFC_DP_READ;
         next_dp_addr = haddr;
      end
   end

   // Data phase write strobes per filter byte.
   always_comb begin
      slot_wr = '0;
      if (phase == CFC_DP_WRITE) begin
         if (dp_addr == CFC_OFF_CTRL_A) begin
            slot_wr[0] = 1'b1; // [RULE6]
            slot_wr[1] = 1'b1;
         end else if (dp_addr == CFC_OFF_CTRL_B) begin
            slot_wr[5:2] = 4'hf; // [RULE5]
         end
      end
   end

   // A read whose address phase overlaps the data phase of a write must see
   // that write, so the image is merged with the write data still in flight.
   always_comb begin
      view_a = ctrl_a;
      view_b = ctrl_b;
      if (slot_wr[0]) begin // [RULE4]
         view_a[31:24] = merge_byte(slot_byte[1], hwdata[31:24]);
         view_a[23:16] = merge_byte(slot_byte[0], hwdata[23:16]);
      end
      if (slot_wr[2]) begin // [RULE4]
         view_b[31:24] = merge_byte(slot_byte[5], hwdata[31:24]);
         view_b[23:16] = merge_byte(slot_byte[4], hwdata[23:16]);
         view_b[15:8]  = merge_byte(slot_byte[3], hwdata[15:8]);
         view_b[7:0]   = merge_byte(slot_byte[2], hwdata[7:0]);
      end
   end

   // Read data, registered at the address phase so it stands in the data phase.
   always_comb begin
      next_hrdata = CFC_RESET_CTRL;
      if (next_phase == CFC_DP_READ) begin
         if (haddr == CFC_OFF_CTRL_A) begin
            next_hrdata = view_a;
         end else if (haddr == CFC_OFF_CTRL_B) begin
            next_hrdata = view_b;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase   <= CFC_DP_IDLE;
         dp_addr <= '0;
         hrdata  <= CFC_RESET_CTRL;
      end else begin
         phase   <= next_phase;
         dp_addr <= next_dp_addr;
         hrdata  <= next_hrdata;
      end
   end

   // Slave is never stalled and never errors.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   for (genvar i = 0; i < CFC_NFILT; i++) begin : g_filt
      logic [7:0] wr_byte;
      always_comb begin
         if (i < CFC_BYTE_BASE_A) begin
            wr_byte = hwdata[(i + CFC_BYTE_BASE_A)*8 +: 8];
         end else begin
            wr_byte = hwdata[(i - CFC_BYTE_BASE_A)*8 +: 8];
         end
      end

      cfc_filter_slot u_slot (
         .hclk      (hclk),
         .hresetn   (hresetn),
         .wr_en     (slot_wr[i]),
         .wr_byte   (wr_byte),
         .ctrl_byte (slot_byte[i])
      );

      cfc_route_decode u_dec (
         .ctrl_byte   (slot_byte[i]),
         .active      (dec_active[i]),
         .mask_onehot (dec_mask[i*4 +: 4]),
         .fifo_onehot (dec_fifo[i*32 +: 32])
      );
   end

   // Filter outputs, index 0 is filter 18, index 5 is filter 23.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         filter_active_bit  <= '0;
         filter_mask_choice <= '0;
         filter_fifo_target <= '0;
         filter_mask_onehot <= '0;
         filter_fifo_onehot <= '0;
      end else begin
         filter_active_bit  <= dec_active; // [RULE1]
         for (int k = 0; k < CFC_NFILT; k++) begin
            filter_mask_choice[k*2 +: 2] <= slot_byte[k][CFC_MASK_HI:CFC_MASK_LO]; // [RULE2]
            filter_fifo_target[k*5 +: 5] <= slot_byte[k][CFC_FIFO_HI:CFC_FIFO_LO]; // [RULE3]
         end
         filter_mask_onehot <= dec_mask; // [RULE7]
         filter_fifo_onehot <= dec_fifo; // [RULE7]
      end
   end

endmodule : cfc_filter_ctrl

// File: verilog/cfc_filter_slot.sv
// Purpose: Holds the control byte of one acceptance filter.
// Assumes: A write strobe with a full byte of data from the bus slave.
// Notes:   Selector fields are locked while the filter is active.
`timescale 1ns/10ps
module cfc_filter_slot
   import cfc_pkg::*;
(
   // Clock and reset.
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Write port.
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_byte,
   // Stored byte.
   output logic      [7:0] ctrl_byte
);

   logic [7:0] next_ctrl_byte;

   always_comb begin
      next_ctrl_byte = ctrl_byte;
      if (wr_en) begin
         // The enable bit is always writable; the selectors only while disabled.
         next_ctrl_byte[CFC_ACTIVE_POS] = wr_byte[CFC_ACTIVE_POS]; // [RULE1]
         if (!ctrl_byte[CFC_ACTIVE_POS]) begin // [RULE4]
            next_ctrl_byte[CFC_MASK_HI:CFC_FIFO_LO] = wr_byte[CFC_MASK_HI:CFC_FIFO_LO];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_byte <= CFC_RESET_BYTE;
      end else begin
         ctrl_byte <= next_ctrl_byte;
      end
   end

endmodule : cfc_filter_slot

// File: verilog/cfc_pkg.sv
// Purpose: Shared constants for the filter control register block.
// Assumes: AHB-Lite register access, 32-bit words, 100 MHz clock.
// Notes:   Two control registers cover filters 18 to 23.
package cfc_pkg;

   localparam int          CFC_ADDR_W      = 8;
   localparam int          CFC_NFILT       = 6;
   localparam int          CFC_FIRST_FILT  = 18;
   localparam logic [7:0]  CFC_OFF_CTRL_A  = 8'h00;
   localparam logic [7:0]  CFC_OFF_CTRL_B  = 8'h04;
   localparam logic [31:0] CFC_RESET_CTRL  = 32'h0000_0000;
   localparam logic [7:0]  CFC_RESET_BYTE  = 8'h00;
   localparam logic [15:0] CFC_RESET_HALF  = 16'h0000;
   localparam int          CFC_BYTE_BASE_A = 2;
   localparam int          CFC_ACTIVE_POS  = 7;
   localparam int          CFC_MASK_HI     = 6;
   localparam int          CFC_MASK_LO     = 5;
   localparam int          CFC_FIFO_HI     = 4;
   localparam int          CFC_FIFO_LO     = 0;
   localparam logic [1:0]  CFC_HTRANS_IDLE = 2'b00;
   localparam logic [2:0]  CFC_HSIZE_WORD  = 3'b010;

   typedef enum logic [1:0] {
      CFC_DP_IDLE  = 2'b00,
      CFC_DP_WRITE = 2'b01,
      CFC_DP_READ  = 2'b11
   } cfc_phase_type;

endpackage : cfc_pkg

// File: verilog/cfc_route_decode.sv
// Purpose: Turns a filter control byte into acceptance and routing controls.
// Assumes: The byte layout of the filter control registers.
// Notes:   Pure combinational decode; the top module registers the results.
`timescale 1ns/10ps
module cfc_route_decode
   import cfc_pkg::*;
(
   // Control byte in.
   input  wire logic [7:0]  ctrl_byte,
   // Decoded controls.
   output logic             active,
   output logic      [3:0]  mask_onehot,
   output logic      [31:0] fifo_onehot
);

   always_comb begin
      active      = ctrl_byte[CFC_ACTIVE_POS]; // [RULE1]
      mask_onehot = 4'h0;
      fifo_onehot = 32'h0000_0000;
      // A disabled filter selects no mask and routes to no buffer.
      if (active) begin // [RULE7]
         mask_onehot[ctrl_byte[CFC_MASK_HI:CFC_MASK_LO]] = 1'b1; // [RULE2]
         fifo_onehot[ctrl_byte[CFC_FIFO_HI:CFC_FIFO_LO]] = 1'b1; // [RULE3]
      end
   end

endmodule : cfc_route_decode
